// ### core/tade_defines.svh
// Constants for the trinary address/data encoder
`ifndef TADE_DEFINES_SVH
`define TADE_DEFINES_SVH
`define TADE_ADDR_N       10
`define TADE_DATA_N       8
`define TADE_SYM_N        18
`define TADE_WORDS        3
`define TADE_CLK_HZ       25000000
`define TADE_ENC_HZ       70000
// Cycles per symbol quarter: clock / (encoder osc), rounded down
`define TADE_QTR_CYC      (`TADE_CLK_HZ / `TADE_ENC_HZ)
// Pilot (low) period between words, in symbol quarters
`define TADE_PILOT_QTR    16
`define TADE_SYNC_QTR     2
// Response lag limit, ms
`define TADE_LAG_MS       150
`endif

// ### core/tade_pkg.sv
// Types for the trinary address/data encoder
`default_nettype none
package tade_pkg;
  typedef enum logic [1:0] {TADE_SYM_LOW, TADE_SYM_HIGH, TADE_SYM_FLOAT} tade_sym_t;
  typedef enum logic [1:0] {TADE_IDLE, TADE_PILOT, TADE_SYNC, TADE_SYMS} tade_state_t;
endpackage
`default_nettype wire

// ### core/tade_sym_shape.sv
// Pulse shaper: maps a tri-state symbol and quarter index to a line level
`default_nettype none
module tade_sym_shape
  import tade_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire tade_pkg::tade_sym_t sym,
  input  wire logic [2:0]      qtr,
  input  wire logic            active,
  output logic                 level
);
  // Symbol made of two bits, each bit four quarters: 0 = 1000, 1 = 1110
  // Low = 00, high = 11, float = 01
  logic bit_val;
  logic [1:0] q;
  always_comb
  begin
    q = qtr[1:0];
    case (sym)
      TADE_SYM_HIGH:  bit_val = 1'b1;
      TADE_SYM_FLOAT: bit_val = qtr[2];
      default:        bit_val = 1'b0;
    endcase
  end
  // Registered line level
  always_ff @(posedge clk)
  begin
    if (rst)
      level <= 1'b0;
    else if (!active)
      level <= 1'b0;
    else
      level <= (q == 2'd0) | (bit_val & (q != 2'd3));
  end
endmodule
`default_nettype wire

// ### core/tade_encoder.sv
// Trinary address/data encoder: sends captured word three times per cycle
// Functional notes
// - Send enable rising starts encoder and captures all address/data states.
// - A cycle is one captured packet sent three times back to back.
// - Enable still high at cycle end starts a new cycle at once.
// - Enable low lets the current cycle finish, then output stops.
// - Ten address then eight data positions, lowest first.
// - High, low and floating inputs each get a distinct symbol.
// - Serial stream drives the transmitter modulation output.
// - Inputs re-sampled at each cycle start; lag stays under 150 ms.
`include "tade_defines.svh"
`default_nettype none
module tade_encoder
  import tade_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        send_enable,
  input  wire logic [9:0]  code_select_lines,
  input  wire logic [9:0]  code_select_lines_drv,
  input  wire logic [7:0]  payload_inputs,
  input  wire logic [7:0]  payload_inputs_drv,
  output logic             modulation_out,
  output logic             busy
);
  import tade_pkg::*;

  localparam int QTR_CYC = `TADE_QTR_CYC;
  localparam int LAG_CYC = `TADE_LAG_MS * (`TADE_CLK_HZ / 1000);

  tade_state_t state;
  tade_sym_t   word [`TADE_SYM_N];
  logic [8:0]  qcnt;          // Clock count inside one quarter
  logic        qtick;
  logic [4:0]  qidx;          // Quarter count inside pilot/sync
  logic [2:0]  sq;            // Quarter index inside a symbol
  logic [4:0]  sidx;          // Symbol index
  logic [1:0]  wcnt;          // Word count in cycle
  logic        run;
  logic        level;

  assign qtick = (qcnt == 9'(QTR_CYC - 1));
  assign run = (state != TADE_IDLE);

  // Quarter timebase from the encoder oscillator rate
  always_ff @(posedge clk)
  begin
    if (rst || !run)
      qcnt <= 9'h000;
    else if (qtick)
      qcnt <= 9'h000;
    else
      qcnt <= qcnt + 9'h001;
  end

  genvar g;
  generate
    for (g = 0; g < `TADE_SYM_N; g++)
    begin : g_cap
      logic drv;
      logic val;
      // Address positions first, then data positions
      if (g < `TADE_ADDR_N)
      begin : g_adr
        assign drv = code_select_lines_drv[g];
        assign val = code_select_lines[g];
      end
      else
      begin : g_dat
        assign drv = payload_inputs_drv[g - `TADE_ADDR_N];
        assign val = payload_inputs[g - `TADE_ADDR_N];
      end
      always_ff @(posedge clk)
      begin
        if (rst)
          word[g] <= TADE_SYM_LOW;
        else if ((state == TADE_IDLE && send_enable)
                 || (state == TADE_SYMS && qtick && sq == 3'd7
                     && sidx == 5'(`TADE_SYM_N - 1) && wcnt == 2'd2 && send_enable))
          word[g] <= !drv ? TADE_SYM_FLOAT : (val ? TADE_SYM_HIGH : TADE_SYM_LOW);
      end
    end
  endgenerate

  // Sequencer: pilot, sync, eighteen symbols, three words per cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= TADE_IDLE;
      qidx  <= 5'h00;
      sq    <= 3'h0;
      sidx  <= 5'h00;
      wcnt  <= 2'h0;
    end
    else
    begin
      case (state)
        TADE_IDLE:
          if (send_enable)
          begin
            state <= TADE_PILOT;
            qidx  <= 5'h00;
            wcnt  <= 2'h0;
          end
        TADE_PILOT:
          if (qtick)
          begin
            if (qidx == 5'(`TADE_PILOT_QTR - 1))
            begin
              qidx  <= 5'h00;
              state <= TADE_SYNC;
            end
            else
              qidx <= qidx + 5'h01;
          end
        TADE_SYNC:
          if (qtick)
          begin
            if (qidx == 5'(`TADE_SYNC_QTR - 1))
            begin
              qidx  <= 5'h00;
              sq    <= 3'h0;
              sidx  <= 5'h00;
              state <= TADE_SYMS;
            end
            else
              qidx <= qidx + 5'h01;
          end
        TADE_SYMS:
          if (qtick)
          begin
            sq <= sq + 3'h1;
            if (sq == 3'd7)
            begin
              // lowest position first, address then data
              if (sidx == 5'(`TADE_SYM_N - 1))
              begin
                sidx <= 5'h00;
                if (wcnt == 2'(`TADE_WORDS - 1))
                begin
                  wcnt <= 2'h0;
                  state <= send_enable ? TADE_PILOT : TADE_IDLE;
                end
                else
                begin
                  wcnt  <= wcnt + 2'h1;
                  state <= TADE_PILOT;
                end
              end
              else
                sidx <= sidx + 5'h01;
            end
          end
        default:
          state <= TADE_IDLE;
      endcase
    end
  end

  tade_sym_shape u_shape (
    .clk    (clk),
    .rst    (rst),
    .sym    (word[sidx]),
    .qtr    (sq),
    .active (state == TADE_SYMS),
    .level  (level)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
      modulation_out <= 1'b0;
    else
      modulation_out <= (state == TADE_SYNC) ? (qidx == 5'h00) : level;
  end

  // Busy flag
  always_ff @(posedge clk)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= run;
  end
endmodule
`default_nettype wire

// ### sim/tade_sva.sv
// Port assertions for the encoder
`default_nettype none
module tade_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic send_enable,
  input wire logic modulation_out,
  input wire logic busy
);
  localparam int CYC = 173498;
  int bc;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Clocks spent busy
  always_ff @(posedge clk)
    bc <= (rst || !busy) ? 0 : bc + 1;
  property p_go; !busy && send_enable |-> ##[1:3] busy; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_pil; $rose(busy) |-> !modulation_out [*8]; endproperty
  a_pil: assert property (p_pil) else $error("no pilot");
  property p_rst; disable iff (1'b0) rst |=> !busy && !modulation_out; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_len; $fell(busy) && !$past(rst) |-> $past(bc) >= CYC; endproperty
  a_len: assert property (p_len) else $error("short cycle");
  property p_q; !busy && !$past(busy) && !$past(busy, 2) |-> !modulation_out; endproperty
  a_q: assert property (p_q) else $error("not quiet");
  property p_hi; $rose(modulation_out) |-> modulation_out [*8]; endproperty
  a_hi: assert property (p_hi) else $error("short high");
  property p_lo; $fell(modulation_out) |-> !modulation_out [*8]; endproperty
  a_lo: assert property (p_lo) else $error("short low");
  property p_own; modulation_out |-> busy; endproperty
  a_own: assert property (p_own) else $error("stray");
  property p_rep; send_enable |-> ##2 busy; endproperty
  a_rep: assert property (p_rep) else $error("no repeat");
endmodule

bind tade_encoder tade_sva u_sva (
  .clk            (clk),
  .rst            (rst),
  .send_enable    (send_enable),
  .modulation_out (modulation_out),
  .busy           (busy)
);
`default_nettype wire

// ### sim/tade_remote_decoder.sv
// Behavioural remote decoder fed by the serial stream
`include "tade_defines.svh"
`default_nettype none
module tade_remote_decoder (
  input  wire logic       clk,
  input  wire logic       line_in,
  input  wire logic [9:0] own_code,
  input  wire logic [9:0] own_drv,
  output logic      [7:0] data_out,
  output int              accepts
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = `TADE_QTR_CYC;
  logic [35:0] b;
  logic        ok;
  initial
  begin
    data_out = 0;
    accepts = 0;
    forever
    begin
      @(posedge line_in);
      repeat (2 * Q) @(posedge clk);
      for (int i = 0; i < 36; i++)
      begin
        repeat (Q + Q / 2) @(posedge clk);
        b[i] = line_in;
        repeat (2 * Q + Q / 2) @(posedge clk);
      end
      ok = 1;
      for (int k = 0; k < 10; k++)
        ok &= ((b[2*k] == b[2*k+1]) == own_drv[k]) && (!own_drv[k] || b[2*k] == own_code[k]);
      if (ok)
      begin
        accepts++;
        for (int k = 0; k < 8; k++)
          data_out[k] = b[20+2*k] & b[21+2*k];
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/trinary_address_data_encoder_test.sv
// Self-checking bench for the encoder
`default_nettype none
module trinary_address_data_encoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, en, mo, busy;
  logic [9:0]  a, ad;
  logic [7:0]  d, dd, got;
  int          acc, acc0, n, bad_count, samples_checked;
  logic [51:0] rows [2] = '{{10'h3a5, 10'h3f0, 8'ha5, 8'h0f, 8'h05, 8'h03},
                           {10'h3a5, 10'h3f1, 8'h5a, 8'hff, 8'h05, 8'h00}};
  tade_encoder uut (.clk(clk), .rst(rst), .send_enable(en), .code_select_lines(a),
    .code_select_lines_drv(ad), .payload_inputs(d), .payload_inputs_drv(dd),
    .modulation_out(mo), .busy(busy));
  tade_remote_decoder rx (.clk(clk), .line_in(mo), .own_code(10'h3a5),
    .own_drv(10'h3f0), .data_out(got), .accepts(acc));
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Rows, then a reset case
  initial
  begin
    rst = 1;
    {en, a, ad, d, dd} = 0;
    repeat (3) @(posedge clk);
    #1 rst = 0;
    chk(mo, 0);
    foreach (rows[i])
    begin
      @(posedge clk);
      #1 {a, ad, d, dd} = rows[i][51:16];
      en = 1;
      acc0 = acc;
      @(posedge clk);
      #1 en = 0;
      repeat (3) @(posedge clk);
      for (n = 0; busy !== 1'b0 && n < 200000; n++)
        @(posedge clk);
      if (n == 200000)
      begin
        bad_count++;
        stop_test;
      end
      repeat (400) @(posedge clk);
      chk(mo, 0);
      chk(got, rows[i][15:8]);
      chk(8'(acc - acc0), rows[i][7:0]);
    end
    @(posedge clk);
    #1 en = 1;
    repeat (900) @(posedge clk);
    #1 rst = 1;
    en = 0;
    @(posedge clk);
    #1 chk({busy, mo}, 0);
    stop_test;
  end
endmodule
`default_nettype wire
